// file: rtl/region_check_regs.vh
`ifndef REGION_CHECK_REGS_VH
`define REGION_CHECK_REGS_VH

// Number of programmable regions
`define RGN_COUNT          8
`define RGN_IDX_W          3
// Attribute word field positions (one word per region)
`define ATTR_ENABLE_BIT    0
`define ATTR_SIZE_LSB      1
`define ATTR_SIZE_MSB      5
`define ATTR_B_BIT         16
`define ATTR_C_BIT         17
`define ATTR_S_BIT         18
`define ATTR_TYPE_EXT_LSB  19
`define ATTR_TYPE_EXT_MSB  21
`define ATTR_PERM_LSB      24
`define ATTR_PERM_MSB      26
`define ATTR_NOEXEC_BIT    28
// Reset values
`define ATTR_RESET         32'h0000_0000
`define BASE_RESET         32'h0000_0000
// Resolved memory type encodings
`define MTYPE_STRONG       2'h0
`define MTYPE_DEVICE       2'h1
`define MTYPE_NORMAL       2'h2
// Cache policy encodings
`define CPOL_NONCACHE      2'h0
`define CPOL_WTHROUGH      2'h1
`define CPOL_WBACK         2'h2
// Access permission encodings
`define PERM_NONE            3'h0
`define PERM_PRIV_RW         3'h1
`define PERM_PRIV_RW_USER_RO 3'h2
`define PERM_FULL            3'h3
`define PERM_PRIV_RO         3'h5
`define PERM_RO              3'h6
`define PERM_RO_ALT          3'h7
// Fault cause encodings
`define FCAUSE_NONE        2'h0
`define FCAUSE_BACKGROUND  2'h1
`define FCAUSE_PERMISSION  2'h2
`define FCAUSE_EXEC_NEVER  2'h3

`endif

// file: rtl/region_match.v
`timescale 1ns/10ps
`default_nettype none
`include "region_check_regs.vh"

module region_match (
  // Region setting
  input  wire [31:0] base_in,
  input  wire [31:0] attr_in,
  // Access address
  input  wire [31:0] addr_in,
  // Result
  output wire        hit_out
);

  wire [4:0]  size_field;
  wire [31:0] mask;
  wire        enabled;

  assign size_field = attr_in[`ATTR_SIZE_MSB:`ATTR_SIZE_LSB];
  assign enabled    = attr_in[`ATTR_ENABLE_BIT];
  // Region spans 2^(size+1) bytes; size 31 covers the whole map
  assign mask = (size_field == 5'h1f) ? 32'h0000_0000 :
                ~((32'h0000_0002 << size_field) - 32'h0000_0001);
  // Base is treated as aligned to the region size, as software must ensure
  assign hit_out = enabled && ((addr_in & mask) == (base_in & mask));

endmodule // region_match

`default_nettype wire

// file: rtl/region_protection_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "region_check_regs.vh"

module region_protection_unit #(
  parameter NREG = `RGN_COUNT
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         rstn_in,
  // Configuration
  input  wire         unit_enable_in,
  input  wire         bg_enable_in,
  input  wire         cfg_we_in,
  input  wire [2:0]   cfg_index_in,
  input  wire [31:0]  cfg_base_in,
  input  wire [31:0]  cfg_attr_in,
  // Access request from core
  input  wire         req_valid_in,
  input  wire [31:0]  req_addr_in,
  input  wire         req_write_in,
  input  wire         req_fetch_in,
  input  wire         req_priv_in,
  // Access toward system bus
  output reg          bus_valid_out,
  output reg  [31:0]  bus_addr_out,
  output reg          bus_write_out,
  output reg          bus_fetch_out,
  output reg          bus_priv_out,
  output reg  [1:0]   bus_mem_type_out,
  output reg          bus_shared_out,
  output reg  [1:0]   bus_cache_pol_out,
  output reg          bus_bufferable_out,
  output reg          bus_ordered_out,
  // Fault report to exception logic
  output reg          fault_out,
  output reg  [1:0]   fault_cause_out,
  output reg  [31:0]  fault_addr_out,
  output reg  [2:0]   hit_region_out,
  output reg          hit_bg_out
);

  reg  [31:0] base_q [0:NREG-1];
  reg  [31:0] attr_q [0:NREG-1];
  wire [NREG-1:0] hit;
  integer k;

  // Per-region storage and matching
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_rgn
      always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          base_q[g] <= `BASE_RESET;
          attr_q[g] <= `ATTR_RESET;
        end else if (cfg_we_in && (cfg_index_in == g)) begin
          base_q[g] <= cfg_base_in;
          attr_q[g] <= cfg_attr_in;
        end
      end
      // Same match logic for fetches and data
      region_match u_match (
        .base_in (base_q[g]),
        .attr_in (attr_q[g]),
        .addr_in (req_addr_in),
        .hit_out (hit[g])
      );
    end
  endgenerate

  // Permission check from access permission and execute-never fields
  function perm_ok;
    input [2:0] perm_f;
    input       noexec_f;
    input       priv;
    input       wr;
    input       fetch;
    begin
      case (perm_f)
        `PERM_PRIV_RW:           perm_ok = priv;
        `PERM_PRIV_RW_USER_RO:   perm_ok = priv || !wr;
        `PERM_FULL:              perm_ok = 1'b1;
        `PERM_PRIV_RO:           perm_ok = priv && !wr;
        `PERM_RO, `PERM_RO_ALT:  perm_ok = !wr;
        default:                 perm_ok = 1'b0;
      endcase
      if (fetch && noexec_f)
        perm_ok = 1'b0;
    end
  endfunction

  // Highest-numbered hit wins
  reg        any_hit;
  reg [2:0]  win;
  always @* begin
    any_hit = 1'b0;
    win     = 3'h0;
    for (k = 0; k < NREG; k = k + 1) begin
      if (hit[k]) begin
        any_hit = 1'b1;
        win     = k[2:0];
      end
    end
  end

  wire [31:0] wattr = attr_q[win];
  wire [2:0]  type_ext = wattr[`ATTR_TYPE_EXT_MSB:`ATTR_TYPE_EXT_LSB];
  wire        c_b   = wattr[`ATTR_C_BIT];
  wire        b_b   = wattr[`ATTR_B_BIT];
  wire        s_b   = wattr[`ATTR_S_BIT];
  wire [2:0]  perm     = wattr[`ATTR_PERM_MSB:`ATTR_PERM_LSB];
  wire        noexec   = wattr[`ATTR_NOEXEC_BIT];

  // Resolution of type, sharing and cache policy
  reg [1:0] mtype_d;
  reg       shared_d;
  reg [1:0] cpol_d;
  reg       buf_d;
  reg       allow_d;
  reg [1:0] cause_d;
  reg       use_bg;
  always @* begin
    use_bg   = 1'b0;
    mtype_d  = `MTYPE_NORMAL;
    shared_d = 1'b0;
    cpol_d   = `CPOL_NONCACHE;
    buf_d    = 1'b0;
    allow_d  = 1'b1;
    cause_d  = `FCAUSE_NONE;
    if (!unit_enable_in) begin
      // Unit off: default map, everything allowed
      mtype_d = `MTYPE_NORMAL;
    end else if (!any_hit) begin
      use_bg = 1'b1;
      // Background gives default map attributes, privileged only
      if (!(bg_enable_in && req_priv_in)) begin
        allow_d = 1'b0;
        cause_d = `FCAUSE_BACKGROUND;
      end
    end else begin
      // Type from type extension, cacheable and bufferable
      if (type_ext == 3'h0 && !c_b && !b_b) begin
        mtype_d  = `MTYPE_STRONG;
        shared_d = 1'b1;
      end else if ((type_ext == 3'h0 && !c_b && b_b) ||
                   (type_ext == 3'h2 && !c_b && !b_b)) begin
        mtype_d  = `MTYPE_DEVICE;
        shared_d = s_b;
        buf_d    = 1'b1;
      end else begin
        mtype_d  = `MTYPE_NORMAL;
        shared_d = s_b;
        buf_d    = b_b;
        if (type_ext[2])
          cpol_d = (type_ext[1:0] == 2'h1) ? `CPOL_WBACK :
                   (type_ext[1:0] == 2'h2) ? `CPOL_WTHROUGH :
                   (type_ext[1:0] == 2'h3) ? `CPOL_WBACK : `CPOL_NONCACHE;
        else if (c_b)
          cpol_d = b_b ? `CPOL_WBACK : `CPOL_WTHROUGH;
        else
          cpol_d = `CPOL_NONCACHE;
      end
      if (!perm_ok(perm, noexec, req_priv_in, req_write_in, req_fetch_in)) begin
        allow_d = 1'b0;
        cause_d = (req_fetch_in && noexec) ? `FCAUSE_EXEC_NEVER : `FCAUSE_PERMISSION;
      end
    end
  end

  // One cycle check stage; order of accesses is kept since the stage never reorders
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_valid_out      <= 1'b0;
      bus_addr_out       <= 32'h0000_0000;
      bus_write_out      <= 1'b0;
      bus_fetch_out      <= 1'b0;
      bus_priv_out       <= 1'b0;
      bus_mem_type_out   <= `MTYPE_NORMAL;
      bus_shared_out     <= 1'b0;
      bus_cache_pol_out  <= `CPOL_NONCACHE;
      bus_bufferable_out <= 1'b0;
      bus_ordered_out    <= 1'b0;
      fault_out          <= 1'b0;
      fault_cause_out    <= `FCAUSE_NONE;
      fault_addr_out     <= 32'h0000_0000;
      hit_region_out     <= 3'h0;
      hit_bg_out         <= 1'b0;
    end else begin
      // Faulted access never reaches the bus
      bus_valid_out      <= req_valid_in && allow_d;
      fault_out          <= req_valid_in && !allow_d;
      if (req_valid_in) begin
        bus_addr_out       <= req_addr_in;
        bus_write_out      <= req_write_in;
        bus_fetch_out      <= req_fetch_in;
        bus_priv_out       <= req_priv_in;
        bus_mem_type_out   <= mtype_d;
        bus_shared_out     <= shared_d;
        bus_cache_pol_out  <= cpol_d;
        bus_bufferable_out <= buf_d;
        bus_ordered_out    <= (mtype_d == `MTYPE_STRONG);
        hit_region_out     <= win;
        hit_bg_out         <= use_bg;
        fault_cause_out    <= cause_d;
        if (!allow_d)
          fault_addr_out <= req_addr_in;
      end
    end
  end

endmodule // region_protection_unit

`default_nettype wire

// file: tb/core_access_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_access_model (
  // Clock
  input  wire logic        clk_in,
  // Access request
  output var  logic        req_valid_out,
  output var  logic [31:0] req_addr_out,
  output var  logic        req_write_out,
  output var  logic        req_fetch_out,
  output var  logic        req_priv_out
);
  initial begin
    req_valid_out = 1'b0;
    req_addr_out  = 32'h0;
    req_write_out = 1'b0;
    req_fetch_out = 1'b0;
    req_priv_out  = 1'b0;
  end
  // Flags ordered as {write, fetch, priv}
  task automatic issue(input logic [31:0] a, input logic [2:0] wfp);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_addr_out  <= a;
    {req_write_out, req_fetch_out, req_priv_out} <= wfp;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    // Idle address flips so a stale copy can never pass for a live one
    req_addr_out  <= ~a;
  endtask
endmodule // core_access_model
`default_nettype wire

// file: tb/region_protection_unit_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rpu_asserts (
  // Clock, reset, controls
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        unit_enable_in,
  input wire logic        bg_enable_in,
  input wire logic        req_valid_in,
  input wire logic [31:0] req_addr_in,
  input wire logic        req_fetch_in,
  input wire logic        req_priv_in,
  // Results
  input wire logic        bus_valid_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic [1:0]  bus_mem_type_out,
  input wire logic        bus_shared_out,
  input wire logic        bus_ordered_out,
  input wire logic        fault_out,
  input wire logic [1:0]  fault_cause_out,
  input wire logic [31:0] fault_addr_out,
  input wire logic        hit_bg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_single_answer: assert property (
    req_valid_in |=> bus_valid_out ^ fault_out) else $error("answer count wrong");
  a_no_spurious: assert property (
    !req_valid_in |=> !(bus_valid_out || fault_out)) else $error("unrequested answer");
  a_addr_follows: assert property (
    bus_valid_out |-> bus_addr_out == $past(req_addr_in)) else $error("bus address wrong");
  a_fault_addr: assert property (
    fault_out |-> fault_addr_out == $past(req_addr_in) && fault_cause_out != 2'h0)
    else $error("fault report wrong");
  a_strong_shared: assert property (
    bus_valid_out && bus_ordered_out |-> bus_shared_out && bus_mem_type_out == 2'h0)
    else $error("ordered access not shared");
  a_bg_priv: assert property (
    bus_valid_out && hit_bg_out && $past(unit_enable_in) |-> $past(req_priv_in && bg_enable_in))
    else $error("background let through");
  a_noexec_fetch: assert property (
    fault_out && fault_cause_out == 2'h3 |-> $past(req_fetch_in))
    else $error("no-execute fault on data access");
  a_off_allows: assert property (
    req_valid_in && !unit_enable_in |=> bus_valid_out) else $error("disabled unit blocked");
endmodule // rpu_asserts
bind region_protection_unit rpu_asserts u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .unit_enable_in(unit_enable_in), .bg_enable_in(bg_enable_in), .req_valid_in(req_valid_in),
  .req_addr_in(req_addr_in), .req_fetch_in(req_fetch_in), .req_priv_in(req_priv_in),
  .bus_valid_out(bus_valid_out), .bus_addr_out(bus_addr_out),
  .bus_mem_type_out(bus_mem_type_out), .bus_shared_out(bus_shared_out),
  .bus_ordered_out(bus_ordered_out), .fault_out(fault_out), .fault_cause_out(fault_cause_out),
  .fault_addr_out(fault_addr_out), .hit_bg_out(hit_bg_out));
`default_nettype wire

// file: tb/region_protection_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "region_check_regs.vh"
module region_protection_unit_bench;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        ue = 1'b0, be = 1'b1, we = 1'b0;
  logic [2:0]  ci = 3'h0;
  logic [31:0] cb = 32'h0, ca = 32'h0;
  wire  logic  rv, rw, rf, rp, bv, bw, bf, bp, bsh, bb, bo, flt, hbg;
  wire  logic [31:0] ra, ba, fa;
  wire  logic [1:0]  bmt, bcp, fc;
  wire  logic [2:0]  hr;
  int          fail_count = 0, num_checks = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  core_access_model m (.clk_in(clk_in), .req_valid_out(rv), .req_addr_out(ra),
    .req_write_out(rw), .req_fetch_out(rf), .req_priv_out(rp));
  region_protection_unit DUT (.clk_in(clk_in), .rstn_in(rstn_in), .unit_enable_in(ue),
    .bg_enable_in(be), .cfg_we_in(we), .cfg_index_in(ci), .cfg_base_in(cb), .cfg_attr_in(ca),
    .req_valid_in(rv), .req_addr_in(ra), .req_write_in(rw), .req_fetch_in(rf),
    .req_priv_in(rp), .bus_valid_out(bv), .bus_addr_out(ba), .bus_write_out(bw),
    .bus_fetch_out(bf), .bus_priv_out(bp), .bus_mem_type_out(bmt), .bus_shared_out(bsh),
    .bus_cache_pol_out(bcp), .bus_bufferable_out(bb), .bus_ordered_out(bo),
    .fault_out(flt), .fault_cause_out(fc), .fault_addr_out(fa), .hit_region_out(hr),
    .hit_bg_out(hbg));
  task automatic results;
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      results;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] at(input logic [4:0] sz, input logic [2:0] perm,
                                     input logic noexec, input logic [2:0] tcb);
    at = {3'h0, noexec, 1'b0, perm, 5'h0, tcb, 10'h0, sz, 1'b1};
  endfunction
  task automatic cfg(input logic [2:0] i, input logic [31:0] b, input logic [31:0] a);
    @(posedge clk_in);
    we <= 1'b1;
    ci <= i;
    cb <= b;
    ca <= a;
    @(posedge clk_in);
    we <= 1'b0;
  endtask
  // Expects a pass when ec is zero, otherwise a fault of cause ec
  task automatic acc(input logic [31:0] a, input logic [2:0] wfp, input logic [1:0] ec);
    m.issue(a, wfp);
    #1;
    chk({bv, flt, fc}, {ec == 2'h0, ec != 2'h0, ec});
    if (ec != 2'h0) begin
      chk(fa, a);
    end else begin
      chk(ba, a);
      chk({bw, bf, bp}, wfp);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    ue <= 1'b1;
    cfg(3'h0, 32'h0, at(5'h1f, `PERM_FULL, 1'b0, 3'h3));
    cfg(3'h3, 32'h2000_0000, at(5'h09, `PERM_FULL, 1'b0, 3'h3));
    cfg(3'h7, 32'h2000_0000, at(5'h09, `PERM_PRIV_RO, 1'b0, 3'h0));
    cfg(3'h6, 32'h3000_0000, at(5'h09, `PERM_FULL, 1'b1, 3'h1));
    // Type extension 110 with shareable set: normal, shared, write-through
    cfg(3'h2, 32'h1000_0000, at(5'h09, `PERM_PRIV_RW_USER_RO, 1'b0, 3'h4) | 32'h0030_0000);
    acc(32'h0000_1000, 3'b000, `FCAUSE_NONE);
    chk(hr, 32'h0);
    chk({bcp, bb}, {`CPOL_WBACK, 1'b1});
    acc(32'h2000_0004, 3'b000, `FCAUSE_PERMISSION);
    acc(32'h2000_0004, 3'b001, `FCAUSE_NONE);
    chk({hr, bmt, bsh, bo}, {3'h7, `MTYPE_STRONG, 2'b11});
    chk({bcp, bb}, {`CPOL_NONCACHE, 1'b0});
    acc(32'h2000_0004, 3'b101, `FCAUSE_PERMISSION);
    acc(32'h3000_0010, 3'b011, `FCAUSE_EXEC_NEVER);
    acc(32'h3000_0010, 3'b000, `FCAUSE_NONE);
    chk({hr, bmt, bsh}, {3'h6, `MTYPE_DEVICE, 1'b0});
    chk({bcp, bb}, {`CPOL_NONCACHE, 1'b1});
    acc(32'h1000_0008, 3'b100, `FCAUSE_PERMISSION);
    acc(32'h1000_0008, 3'b000, `FCAUSE_NONE);
    chk({hr, bmt, bsh, bcp, bb}, {3'h2, `MTYPE_NORMAL, 1'b1, `CPOL_WTHROUGH, 1'b0});
    acc(32'h2000_0400, 3'b100, `FCAUSE_NONE);
    chk(hr, 32'h0);
    cfg(3'h0, 32'h0, 32'h0);
    acc(32'h0000_1000, 3'b000, `FCAUSE_BACKGROUND);
    acc(32'h0000_1000, 3'b101, `FCAUSE_NONE);
    chk(hbg, 32'h1);
    @(posedge clk_in);
    be <= 1'b0;
    acc(32'h0000_1000, 3'b001, `FCAUSE_BACKGROUND);
    @(posedge clk_in);
    ue <= 1'b0;
    acc(32'h0000_1000, 3'b100, `FCAUSE_NONE);
    chk({bmt, bcp, hbg}, {`MTYPE_NORMAL, `CPOL_NONCACHE, 1'b0});
    // Reset in mid-run must clear every region as well as the outputs
    @(posedge clk_in);
    rstn_in <= 1'b0;
    ue <= 1'b1;
    be <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk({bv, flt, bmt, hbg, hr}, {2'b00, `MTYPE_NORMAL, 1'b0, 3'h0});
    @(posedge clk_in);
    rstn_in <= 1'b1;
    acc(32'h2000_0004, 3'b001, `FCAUSE_NONE);
    chk({hbg, hr}, {1'b1, 3'h0});
    results;
  end
endmodule // region_protection_unit_bench
`default_nettype wire
